// [bench/pdb_bank_props.sv]
// Concurrent checks on the peripheral disable bank ports
`timescale 1ns/1ps
module pdb_bank_props #(
   parameter int ADDR_W = 8,
   parameter logic [pdb_pkg::PERIPH_COUNT-1:0] PRESENT_MASK = {pdb_pkg::PERIPH_COUNT{1'b1}}
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic nrst_i,
   // Register bus
   input wire logic [ADDR_W-1:0] s_axi_awaddr_i,
   input wire logic s_axi_awvalid_i,
   input wire logic s_axi_awready_o,
   input wire logic [31:0] s_axi_wdata_i,
   input wire logic [3:0] s_axi_wstrb_i,
   input wire logic s_axi_wvalid_i,
   input wire logic s_axi_wready_o,
   input wire logic [1:0] s_axi_bresp_o,
   input wire logic s_axi_bvalid_o,
   input wire logic s_axi_bready_i,
   input wire logic [ADDR_W-1:0] s_axi_araddr_i,
   input wire logic s_axi_arvalid_i,
   input wire logic s_axi_arready_o,
   input wire logic [31:0] s_axi_rdata_o,
   input wire logic s_axi_rvalid_o,
   input wire logic s_axi_rready_i,
   // Off lines and enables
   input wire logic converter_one_off_o,
   input wire logic can_one_off_o,
   input wire logic can_two_off_o,
   input wire logic [7:0] compare_off_o,
   input wire logic [7:0] capture_off_o,
   input wire logic converter_two_off_o,
   input wire logic twowire_two_off_o,
   input wire logic [3:0] timer_off_o,
   input wire logic [pdb_pkg::PERIPH_COUNT-1:0] periph_clk_en_o,
   input wire logic [pdb_pkg::PERIPH_COUNT-1:0] periph_acc_en_o
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!nrst_i);
   logic [pdb_pkg::PERIPH_COUNT-1:0] off_vec;
   assign off_vec = {timer_off_o, twowire_two_off_o, converter_two_off_o, capture_off_o, compare_off_o,
                     can_two_off_o, can_one_off_o, converter_one_off_o};
   sequence wr_taken(logic [7:0] a);
      s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o && s_axi_awaddr_i == a;
   endsequence
   sequence rd_taken(logic [7:0] a);
      s_axi_arvalid_i && s_axi_arready_o && s_axi_araddr_i == a;
   endsequence
   a_clk_en_follows: assert property (periph_clk_en_o == (PRESENT_MASK & ~off_vec))
      else $error("clock enables disagree with off lines");
   a_acc_en_follows: assert property (periph_acc_en_o == (PRESENT_MASK & ~off_vec))
      else $error("access enables disagree with off lines");
   a_can_two_delay: assert property (wr_taken(pdb_pkg::CTRL_1_OFFSET) ##0 s_axi_wstrb_i[0]
      |-> ##1 $stable(can_two_off_o) ##1 can_two_off_o == $past(s_axi_wdata_i[2], 2))
      else $error("can two off line wrong after write");
   a_timer_delay: assert property (wr_taken(pdb_pkg::CTRL_3_OFFSET) ##0 s_axi_wstrb_i[1]
      |-> ##2 timer_off_o == $past(s_axi_wdata_i[15:12], 2))
      else $error("timer off lines wrong after write");
   a_wr_resp_next: assert property (s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o
      |=> s_axi_bvalid_o) else $error("write response missing");
   a_bresp_holds: assert property (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o && $stable(s_axi_bresp_o))
      else $error("write response dropped early");
   a_rdata_holds: assert property (s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o))
      else $error("read data dropped early");
   a_upper_half_zero: assert property (s_axi_rvalid_o |-> s_axi_rdata_o[31:16] == 16'h0000)
      else $error("upper read half not zero");
   a_gap_reads_zero: assert property (rd_taken(pdb_pkg::CTRL_3_OFFSET) |=> s_axi_rdata_o[11:2] == 10'h000)
      else $error("unimplemented bits read nonzero");
endmodule // pdb_bank_props
bind pdb_bank pdb_bank_props #(.ADDR_W(ADDR_W), .PRESENT_MASK(PRESENT_MASK)) u_props (.*);

// [bench/tb_pdb_bank.sv]
// Self-checking bench for the peripheral disable bank
`timescale 1ns/1ps
module tb_pdb_bank;
   // Two peripherals absent to show presence gating
   localparam logic [24:0] MASK = 25'h0ff_fffe;
   logic clk_i = 1'b0, nrst_i = 1'b0;
   logic [7:0] s_axi_awaddr_i = 8'h00, s_axi_araddr_i = 8'h00;
   logic [31:0] s_axi_wdata_i = 32'h0000_0000;
   logic [3:0] s_axi_wstrb_i = 4'h0;
   logic s_axi_awvalid_i = 1'b0, s_axi_wvalid_i = 1'b0, s_axi_bready_i = 1'b0;
   logic s_axi_arvalid_i = 1'b0, s_axi_rready_i = 1'b0;
   logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
   logic [1:0] s_axi_bresp_o, s_axi_rresp_o;
   logic [31:0] s_axi_rdata_o;
   logic converter_one_off_o, can_one_off_o, can_two_off_o, converter_two_off_o, twowire_two_off_o;
   logic [7:0] compare_off_o, capture_off_o;
   logic [3:0] timer_off_o;
   logic [24:0] periph_clk_en_o, periph_acc_en_o, off_vec;
   logic [15:0] sh [3];
   logic [7:0] offs [3] = '{pdb_pkg::CTRL_1_OFFSET, pdb_pkg::CTRL_2_OFFSET, pdb_pkg::CTRL_3_OFFSET};
   logic [15:0] msk [3] = '{pdb_pkg::CTRL_1_MASK, pdb_pkg::CTRL_2_MASK, pdb_pkg::CTRL_3_MASK};
   int error_cnt = 0, checks = 0;
   pdb_bank #(.ADDR_W(8), .PRESENT_MASK(MASK)) uut (.*);
   assign off_vec = {timer_off_o, twowire_two_off_o, converter_two_off_o, capture_off_o, compare_off_o,
                     can_two_off_o, can_one_off_o, converter_one_off_o};
   always #10 clk_i = ~clk_i;
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected %s: expected %h, seen %h", name, exp, got);
      end
   endtask
   task automatic summarize();
      $display("checks %0d, errors %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   // Ready is sampled mid-cycle, so it is the value seen at the next rising edge
   task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
      logic pa = 1'b1, pw = 1'b1, ta, tw;
      @(posedge clk_i);
      s_axi_awaddr_i <= a;
      s_axi_wdata_i <= d;
      s_axi_wstrb_i <= s;
      s_axi_awvalid_i <= 1'b1;
      s_axi_wvalid_i <= 1'b1;
      while (pa || pw) begin
         @(negedge clk_i);
         ta = pa && s_axi_awready_o;
         tw = pw && s_axi_wready_o;
         @(posedge clk_i);
         if (ta) s_axi_awvalid_i <= 1'b0;
         if (tw) s_axi_wvalid_i <= 1'b0;
         pa = pa && !ta;
         pw = pw && !tw;
      end
      do @(negedge clk_i); while (s_axi_bvalid_o !== 1'b1);
      // Late ready exercises the hold of the response
      @(posedge clk_i);
      s_axi_bready_i <= 1'b1;
      @(negedge clk_i);
      r = s_axi_bresp_o;
      @(posedge clk_i);
      s_axi_bready_i <= 1'b0;
   endtask
   task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge clk_i);
      s_axi_araddr_i <= a;
      s_axi_arvalid_i <= 1'b1;
      do @(negedge clk_i); while (s_axi_arready_o !== 1'b1);
      @(posedge clk_i);
      s_axi_arvalid_i <= 1'b0;
      do @(negedge clk_i); while (s_axi_rvalid_o !== 1'b1);
      @(posedge clk_i);
      s_axi_rready_i <= 1'b1;
      @(negedge clk_i);
      d = s_axi_rdata_o;
      r = s_axi_rresp_o;
      @(posedge clk_i);
      s_axi_rready_i <= 1'b0;
   endtask
   function automatic logic [24:0] exp_off();
      return {sh[2][15:12], sh[2][1:0], sh[1], sh[0][2:0]};
   endfunction
   task automatic check_all();
      logic [31:0] d;
      logic [1:0] r;
      for (int i = 0; i < 3; i++) begin
         axi_read(offs[i], d, r);
         chk("read data", {16'h0000, sh[i]}, d);
         chk("read resp", 32'(pdb_pkg::RESP_OKAY), 32'(r));
      end
      // Look away from the launching edge
      @(negedge clk_i);
      chk("off lines", 32'(exp_off()), 32'(off_vec));
      chk("clock enables", 32'(MASK & ~exp_off()), 32'(periph_clk_en_o));
      chk("access enables", 32'(MASK & ~exp_off()), 32'(periph_acc_en_o));
   endtask
   task automatic reg_wr(input int i, input logic [31:0] d, input logic [3:0] s);
      logic [1:0] r;
      axi_write(offs[i], d, s, r);
      chk("write resp", 32'(pdb_pkg::RESP_OKAY), 32'(r));
      if (s[0]) sh[i][7:0] = d[7:0] & msk[i][7:0];
      if (s[1]) sh[i][15:8] = d[15:8] & msk[i][15:8];
      check_all();
   endtask
   initial begin
      logic [31:0] d;
      logic [1:0] r;
      sh = '{16'h0000, 16'h0000, 16'h0000};
      repeat (12) @(posedge clk_i);
      nrst_i <= 1'b1;
      check_all();
      for (int i = 0; i < 3; i++) begin
         // Walk one bit per register, upper bus half always set
         for (int k = 0; k < 16; k++) begin
            reg_wr(i, 32'hffff_0000 | (32'h0000_0001 << k), 4'b0011);
         end
         reg_wr(i, 32'hffff_ffff, 4'b0011);
      end
      reg_wr(1, 32'h0000_0000, 4'b0001);
      reg_wr(1, 32'h0000_0000, 4'b0000);
      reg_wr(2, 32'h0000_0000, 4'b0010);
      axi_write(8'h0c, 32'h0000_ffff, 4'b0011, r);
      chk("unmapped write resp", 32'(pdb_pkg::RESP_SLVERR), 32'(r));
      axi_read(8'h0c, d, r);
      chk("unmapped read data", 32'h0000_0000, d);
      chk("unmapped read resp", 32'(pdb_pkg::RESP_SLVERR), 32'(r));
      check_all();
      @(posedge clk_i);
      nrst_i <= 1'b0;
      repeat (3) @(posedge clk_i);
      nrst_i <= 1'b1;
      sh = '{16'h0000, 16'h0000, 16'h0000};
      check_all();
      summarize();
   end
   // Run needs under two thousand cycles
   initial begin
      #400000;
      error_cnt++;
      summarize();
   end
endmodule // tb_pdb_bank

// [rtl/pdb_bank.sv]
// Peripheral disable register bank with AXI4-Lite slave
// Summary of operation
// - Control one bit 2 turns off CAN two
// - Control one bit 1 turns off CAN one
// - Control one bit 0 turns off converter one
// - Control two bits 15..8 turn off captures 8..1
// - Control two bits 7..0 turn off compares 8..1
// - Control three bits 15..12 turn off timers 9..6
// - Control three bits 11..2 read zero, ignore writes
// - Control three bit 1 turns off two-wire two
// - Control three bit 0 turns off converter two
// - All implemented bits read/write, zero after reset
// - Set bit stops the peripheral's clocks
// - Set bit blocks the peripheral's register access
// - Change reaches peripheral one cycle later
// - Enabled only if bit clear and present
//
// Our own choices: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module pdb_bank #(
   parameter int ADDR_W = 8,
   parameter logic [pdb_pkg::PERIPH_COUNT-1:0] PRESENT_MASK = {pdb_pkg::PERIPH_COUNT{1'b1}}
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic nrst_i,
   // AXI4-Lite write address
   input wire logic [ADDR_W-1:0] s_axi_awaddr_i,
   input wire logic s_axi_awvalid_i,
   output logic s_axi_awready_o,
   // AXI4-Lite write data
   input wire logic [31:0] s_axi_wdata_i,
   input wire logic [3:0] s_axi_wstrb_i,
   input wire logic s_axi_wvalid_i,
   output logic s_axi_wready_o,
   // AXI4-Lite write response
   output logic [1:0] s_axi_bresp_o,
   output logic s_axi_bvalid_o,
   input wire logic s_axi_bready_i,
   // AXI4-Lite read address
   input wire logic [ADDR_W-1:0] s_axi_araddr_i,
   input wire logic s_axi_arvalid_i,
   output logic s_axi_arready_o,
   // AXI4-Lite read data
   output logic [31:0] s_axi_rdata_o,
   output logic [1:0] s_axi_rresp_o,
   output logic s_axi_rvalid_o,
   input wire logic s_axi_rready_i,
   // Per-peripheral off lines
   output logic converter_one_off_o,
   output logic can_one_off_o,
   output logic can_two_off_o,
   output logic [pdb_pkg::CHANNEL_COUNT-1:0] compare_off_o,
   output logic [pdb_pkg::CHANNEL_COUNT-1:0] capture_off_o,
   output logic converter_two_off_o,
   output logic twowire_two_off_o,
   output logic [pdb_pkg::TIMER_COUNT-1:0] timer_off_o,
   // Per-peripheral clock and register access enables
   output logic [pdb_pkg::PERIPH_COUNT-1:0] periph_clk_en_o,
   output logic [pdb_pkg::PERIPH_COUNT-1:0] periph_acc_en_o
);

   localparam int N = pdb_pkg::PERIPH_COUNT;

   typedef struct packed {
      logic [15:0] module_disable_ctrl_1;
      logic [15:0] module_disable_ctrl_2;
      logic [15:0] module_disable_ctrl_3;
      logic aw_held;
      logic [ADDR_W-1:0] aw_addr;
      logic w_held;
      logic [15:0] w_data;
      logic [1:0] w_strb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } pdb_bank_state_type;

   pdb_bank_state_type state_reg;
   pdb_bank_state_type state_next;

   logic [N-1:0] off_req;
   logic [N-1:0] off_line;
   logic [N-1:0] clk_en;
   logic [N-1:0] acc_en;

   // Byte-lane merge limited to implemented bits
   function automatic logic [15:0] merge16(
      input logic [15:0] old_val,
      input logic [15:0] wr_val,
      input logic [1:0] strb,
      input logic [15:0] mask
   );
      logic [15:0] lanes;
      lanes = {{8{strb[1]}}, {8{strb[0]}}};
      merge16 = (old_val & ~(lanes & mask)) | (wr_val & lanes & mask);
   endfunction

   function automatic logic is_mapped(input logic [ADDR_W-1:0] addr);
      is_mapped = (addr[ADDR_W-1:2] == pdb_pkg::CTRL_1_OFFSET[ADDR_W-1:2])
         || (addr[ADDR_W-1:2] == pdb_pkg::CTRL_2_OFFSET[ADDR_W-1:2])
         || (addr[ADDR_W-1:2] == pdb_pkg::CTRL_3_OFFSET[ADDR_W-1:2]);
   endfunction

   // Bus handshakes: one write and one read outstanding at most
   assign s_axi_awready_o = ~state_reg.aw_held & ~state_reg.bvalid;
   assign s_axi_wready_o = ~state_reg.w_held & ~state_reg.bvalid;
   assign s_axi_arready_o = ~state_reg.rvalid;

   always_comb begin
      logic [ADDR_W-3:0] widx;
      logic [ADDR_W-3:0] ridx;
      widx = '0;
      ridx = '0;
      state_next = state_reg;

      // Retire finished responses first so a new one is never dropped
      if (state_reg.bvalid && s_axi_bready_i) begin
         state_next.bvalid = 1'b0;
      end
      if (state_reg.rvalid && s_axi_rready_i) begin
         state_next.rvalid = 1'b0;
      end

      // Address and data may arrive in either order
      if (s_axi_awvalid_i && s_axi_awready_o) begin
         state_next.aw_held = 1'b1;
         state_next.aw_addr = s_axi_awaddr_i;
      end
      if (s_axi_wvalid_i && s_axi_wready_o) begin
         state_next.w_held = 1'b1;
         state_next.w_data = s_axi_wdata_i[15:0];
         state_next.w_strb = s_axi_wstrb_i[1:0];
      end

      // Commit once both halves are in hand
      if (state_next.aw_held && state_next.w_held && !state_reg.bvalid) begin
         widx = state_next.aw_addr[ADDR_W-1:2];
         state_next.aw_held = 1'b0;
         state_next.w_held = 1'b0;
         state_next.bvalid = 1'b1;
         state_next.bresp = pdb_pkg::RESP_OKAY;
         if (widx == pdb_pkg::CTRL_1_OFFSET[ADDR_W-1:2]) begin
            state_next.module_disable_ctrl_1 = merge16(state_reg.module_disable_ctrl_1,
               state_next.w_data, state_next.w_strb, pdb_pkg::CTRL_1_MASK);
         end else if (widx == pdb_pkg::CTRL_2_OFFSET[ADDR_W-1:2]) begin
            state_next.module_disable_ctrl_2 = merge16(state_reg.module_disable_ctrl_2,
               state_next.w_data, state_next.w_strb, pdb_pkg::CTRL_2_MASK);
         end else if (widx == pdb_pkg::CTRL_3_OFFSET[ADDR_W-1:2]) begin
            // Unimplemented middle bits are masked out here
            state_next.module_disable_ctrl_3 = merge16(state_reg.module_disable_ctrl_3,
               state_next.w_data, state_next.w_strb, pdb_pkg::CTRL_3_MASK);
         end else begin
            state_next.bresp = pdb_pkg::RESP_SLVERR;
         end
      end

      // Reads answer the cycle after the address is taken
      if (s_axi_arvalid_i && s_axi_arready_o) begin
         ridx = s_axi_araddr_i[ADDR_W-1:2];
         state_next.rvalid = 1'b1;
         state_next.rresp = is_mapped(s_axi_araddr_i) ? pdb_pkg::RESP_OKAY : pdb_pkg::RESP_SLVERR;
         if (ridx == pdb_pkg::CTRL_1_OFFSET[ADDR_W-1:2]) begin
            state_next.rdata = {16'h0000, state_reg.module_disable_ctrl_1 & pdb_pkg::CTRL_1_MASK};
         end else if (ridx == pdb_pkg::CTRL_2_OFFSET[ADDR_W-1:2]) begin
            state_next.rdata = {16'h0000, state_reg.module_disable_ctrl_2 & pdb_pkg::CTRL_2_MASK};
         end else if (ridx == pdb_pkg::CTRL_3_OFFSET[ADDR_W-1:2]) begin
            state_next.rdata = {16'h0000, state_reg.module_disable_ctrl_3 & pdb_pkg::CTRL_3_MASK};
         end else begin
            state_next.rdata = 32'h0000_0000;
         end
      end
   end

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         state_reg.module_disable_ctrl_1 <= pdb_pkg::CTRL_1_RESET;
         state_reg.module_disable_ctrl_2 <= pdb_pkg::CTRL_2_RESET;
         state_reg.module_disable_ctrl_3 <= pdb_pkg::CTRL_3_RESET;
         state_reg.aw_held <= 1'b0;
         state_reg.aw_addr <= '0;
         state_reg.w_held <= 1'b0;
         state_reg.w_data <= 16'h0000;
         state_reg.w_strb <= 2'b00;
         state_reg.bvalid <= 1'b0;
         state_reg.bresp <= pdb_pkg::RESP_OKAY;
         state_reg.rvalid <= 1'b0;
         state_reg.rdata <= 32'h0000_0000;
         state_reg.rresp <= pdb_pkg::RESP_OKAY;
      end else begin
         state_reg <= state_next;
      end
   end

   assign s_axi_bvalid_o = state_reg.bvalid;
   assign s_axi_bresp_o = state_reg.bresp;
   assign s_axi_rvalid_o = state_reg.rvalid;
   assign s_axi_rdata_o = state_reg.rdata;
   assign s_axi_rresp_o = state_reg.rresp;

   // Flatten the register bits into peripheral order
   always_comb begin
      off_req = '0;
      off_req[pdb_pkg::IDX_CONVERTER_ONE] = state_reg.module_disable_ctrl_1[pdb_pkg::CONVERTER_ONE_OFF_BIT];
      off_req[pdb_pkg::IDX_CAN_ONE] = state_reg.module_disable_ctrl_1[pdb_pkg::CAN_ONE_OFF_BIT];
      off_req[pdb_pkg::IDX_CAN_TWO] = state_reg.module_disable_ctrl_1[pdb_pkg::CAN_TWO_OFF_BIT];
      for (int i = 0; i < pdb_pkg::CHANNEL_COUNT; i++) begin
         off_req[pdb_pkg::IDX_COMPARE_LSB + i] =
            state_reg.module_disable_ctrl_2[pdb_pkg::COMPARE_OFF_LSB + i];
         off_req[pdb_pkg::IDX_CAPTURE_LSB + i] =
            state_reg.module_disable_ctrl_2[pdb_pkg::CAPTURE_OFF_LSB + i];
      end
      off_req[pdb_pkg::IDX_CONVERTER_TWO] = state_reg.module_disable_ctrl_3[pdb_pkg::CONVERTER_TWO_OFF_BIT];
      off_req[pdb_pkg::IDX_TWOWIRE_TWO] = state_reg.module_disable_ctrl_3[pdb_pkg::TWOWIRE_TWO_OFF_BIT];
      for (int i = 0; i < pdb_pkg::TIMER_COUNT; i++) begin
         off_req[pdb_pkg::IDX_TIMER_LSB + i] = state_reg.module_disable_ctrl_3[pdb_pkg::TIMER_OFF_LSB + i];
      end
   end

   // One gate per peripheral; enables feed an integrated clock gate downstream
   genvar g;
   generate
      for (g = 0; g < N; g++) begin : gen_gate
         pdb_gate_if link ();
         assign link.off_req = off_req[g];
         assign off_line[g] = link.off_line;
         assign clk_en[g] = link.clk_en;
         assign acc_en[g] = link.acc_en;
         pdb_gate #(
            .PRESENT(PRESENT_MASK[g]),
            .DELAY(pdb_pkg::TAKE_EFFECT_CYCLES)
         ) u_gate (
            .clk_i(clk_i),
            .nrst_i(nrst_i),
            .port_i(link.gate)
         );
      end
   endgenerate

   assign converter_one_off_o = off_line[pdb_pkg::IDX_CONVERTER_ONE];
   assign can_one_off_o = off_line[pdb_pkg::IDX_CAN_ONE];
   assign can_two_off_o = off_line[pdb_pkg::IDX_CAN_TWO];
   assign compare_off_o = off_line[pdb_pkg::IDX_COMPARE_LSB +: pdb_pkg::CHANNEL_COUNT];
   assign capture_off_o = off_line[pdb_pkg::IDX_CAPTURE_LSB +: pdb_pkg::CHANNEL_COUNT];
   assign converter_two_off_o = off_line[pdb_pkg::IDX_CONVERTER_TWO];
   assign twowire_two_off_o = off_line[pdb_pkg::IDX_TWOWIRE_TWO];
   assign timer_off_o = off_line[pdb_pkg::IDX_TIMER_LSB +: pdb_pkg::TIMER_COUNT];
   assign periph_clk_en_o = clk_en;
   assign periph_acc_en_o = acc_en;

endmodule // pdb_bank

// [rtl/pdb_gate.sv]
// One peripheral's delayed disable, clock enable and access enable
`timescale 1ns/1ps
module pdb_gate #(
   parameter bit PRESENT = 1'b1,
   parameter int DELAY = pdb_pkg::TAKE_EFFECT_CYCLES
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic nrst_i,
   // Bank side
   pdb_gate_if.gate port_i
);

   typedef struct packed {
      logic [DELAY-1:0] pipe;
      logic clk_en;
      logic acc_en;
   } pdb_gate_state_type;

   pdb_gate_state_type state_reg;
   pdb_gate_state_type state_next;

   always_comb begin
      state_next = state_reg;
      // Peripheral sees the new bit DELAY cycles after the write
      state_next.pipe = DELAY'({state_reg.pipe, port_i.off_req});
      // Absent peripherals never run, whatever the bit says
      // Enables follow the delayed bit so they never lead the off line
      state_next.clk_en = PRESENT & ~state_next.pipe[DELAY-1];
      state_next.acc_en = PRESENT & ~state_next.pipe[DELAY-1];
   end

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         state_reg.pipe <= '0;
         state_reg.clk_en <= PRESENT;
         state_reg.acc_en <= PRESENT;
      end else begin
         state_reg <= state_next;
      end
   end

   assign port_i.off_line = state_reg.pipe[DELAY-1];
   assign port_i.clk_en = state_reg.clk_en;
   assign port_i.acc_en = state_reg.acc_en;

endmodule // pdb_gate

// [rtl/pdb_gate_if.sv]
// Carrier between the register bank and one peripheral gate
`timescale 1ns/1ps
interface pdb_gate_if;
   logic off_req;
   logic off_line;
   logic clk_en;
   logic acc_en;

   modport ctrl (
      output off_req,
      input off_line,
      input clk_en,
      input acc_en
   );
   modport gate (
      input off_req,
      output off_line,
      output clk_en,
      output acc_en
   );
endinterface

// [rtl/pdb_pkg.sv]
// Constants shared by the peripheral disable bank
package pdb_pkg;

   // Register byte offsets on the AXI4-Lite bus
   localparam logic [7:0] CTRL_1_OFFSET = 8'h00;
   localparam logic [7:0] CTRL_2_OFFSET = 8'h04;
   localparam logic [7:0] CTRL_3_OFFSET = 8'h08;

   // Implemented bits of each register
   localparam logic [15:0] CTRL_1_MASK = 16'h0007;
   localparam logic [15:0] CTRL_2_MASK = 16'hFFFF;
   localparam logic [15:0] CTRL_3_MASK = 16'hF003;

   // Values after power-on reset
   localparam logic [15:0] CTRL_1_RESET = 16'h0000;
   localparam logic [15:0] CTRL_2_RESET = 16'h0000;
   localparam logic [15:0] CTRL_3_RESET = 16'h0000;

   // Field positions, first register
   localparam int CONVERTER_ONE_OFF_BIT = 0;
   localparam int CAN_ONE_OFF_BIT = 1;
   localparam int CAN_TWO_OFF_BIT = 2;
   // Second register: compare channels 1..8 in bits 0..7, capture 1..8 in bits 8..15
   localparam int COMPARE_OFF_LSB = 0;
   localparam int CAPTURE_OFF_LSB = 8;
   localparam int CHANNEL_COUNT = 8;
   // Third register
   localparam int CONVERTER_TWO_OFF_BIT = 0;
   localparam int TWOWIRE_TWO_OFF_BIT = 1;
   localparam int TIMER_OFF_LSB = 12;
   localparam int TIMER_COUNT = 4;

   // Positions in the flat per-peripheral vectors
   localparam int PERIPH_COUNT = 25;
   localparam int IDX_CONVERTER_ONE = 0;
   localparam int IDX_CAN_ONE = 1;
   localparam int IDX_CAN_TWO = 2;
   localparam int IDX_COMPARE_LSB = 3;
   localparam int IDX_CAPTURE_LSB = 11;
   localparam int IDX_CONVERTER_TWO = 19;
   localparam int IDX_TWOWIRE_TWO = 20;
   localparam int IDX_TIMER_LSB = 21;

   // Cycles from a register write to the peripheral seeing it
   localparam int TAKE_EFFECT_CYCLES = 1;

   // AXI responses
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage
